// >>> pic_pkg.sv
// constants and types shared by the prioritized interrupt controller
package pic_pkg;

  // special function register byte addresses
  localparam logic [19:0] ADDR_EN_LO = 20'h0003A;
  localparam logic [19:0] ADDR_EN_HI = 20'h0003B;
  localparam logic [19:0] ADDR_PL_LO = 20'h0003C;
  localparam logic [19:0] ADDR_PL_HI = 20'h0003D;

  // field layout of the enable and pending words
  localparam int MASTER_BIT = 0;
  localparam logic [15:0] SRC_EN_MASK = 16'hFFF0;
  localparam logic [15:0] LATCH_MASK = 16'hFFFC;
  localparam logic [15:0] ENABLE_RESET = 16'h0000;
  localparam logic [15:0] LATCH_RESET = 16'h0000;

  // source numbers with special handling
  localparam logic [3:0] SRC_SOFT = 4'h1;
  localparam logic [3:0] SRC_WDOG = 4'h2;
  localparam logic [3:0] SRC_EXT0 = 4'h3;
  localparam int FIRST_MASKABLE = 4;

  // vector table: reset vector on top, sources step down by four
  localparam logic [19:0] VEC_RESET = 20'hFFFFC;
  localparam int VEC_SHIFT = 2;

  // acceptance sequence steps, one machine cycle per clock
  localparam logic [3:0] ACC_LAST = 4'hB;
  localparam logic [3:0] PUSH_LAST = 4'h4;
  localparam logic [3:0] VRD_FIRST = 4'h5;
  localparam logic [3:0] VRD_LAST = 4'h8;
  localparam logic [3:0] CAP_FIRST = 4'h7;
  localparam logic [3:0] CAP_MID = 4'h8;
  localparam logic [3:0] CAP_TOP = 4'h9;
  localparam logic [3:0] CAP_BANK = 4'hA;

  // return sequence: five pops
  localparam logic [3:0] POP_LAST = 4'h4;

  // stack byte codes, in push order
  localparam logic [2:0] STK_PSWH = 3'h0;
  localparam logic [2:0] STK_PCL = 3'h4;

  // controller states, one-hot
  typedef enum logic [2:0] {
    PIC_IDLE = 3'b001,
    PIC_ACC = 3'b010,
    PIC_RET = 3'b100
  } pic_state_t;

endpackage : pic_pkg

// >>> pic_prio_if.sv
// carrier between the controller and its priority encoder
`timescale 1ns/1ps
`default_nettype none
interface pic_prio_if;
  logic [15:0] elig; // acceptable requests, one bit per source
  logic hit; // at least one acceptable request
  logic [3:0] idx; // winning source number

  modport enc (input elig, output hit, output idx);
  modport ctl (output elig, input hit, input idx);
endinterface : pic_prio_if
`default_nettype wire

// >>> pic_prio_enc.sv
// fixed priority encoder: lowest source number wins
`timescale 1ns/1ps
`default_nettype none
module pic_prio_enc (
  pic_prio_if.enc pif
);

  // scan downward so the last match, the lowest number, stays
  always_comb begin
    pif.hit = 1'b0;
    pif.idx = 4'h0;
    for (int i = 15; i >= 1; i--) begin
      if (pif.elig[i]) begin
        pif.hit = 1'b1;
        pif.idx = 4'(i);
      end
    end
  end

endmodule : pic_prio_enc
`default_nettype wire

// >>> pic_ctrl.sv
// prioritized vectored interrupt controller top
`timescale 1ns/1ps
`default_nettype none
module pic_ctrl (
  // clock and reset
  input wire logic CLK_I,
  input wire logic SYS_RST_I,
  // special function register access from the cpu
  input wire logic [19:0] SFR_ADDR_I,
  input wire logic SFR_WR_I,
  input wire logic [7:0] SFR_WDATA_I,
  output logic [7:0] SFR_RDATA_O,
  // request lines from peripherals and pin logic
  input wire logic [15:0] IRQ_I,
  input wire logic EXT0_PIN_EN_I,
  // instruction events from the cpu core
  input wire logic INSTR_LAST_I,
  input wire logic SOFT_TRAP_I,
  input wire logic MASK_RET_I,
  input wire logic NMASK_RET_I,
  input wire logic [3:0] RET_BANK_I,
  // stack and vector fetch requests to the cpu core
  output logic BUSY_O,
  output logic STACK_PUSH_O,
  output logic STACK_POP_O,
  output logic [2:0] STACK_SEL_O,
  output logic VEC_RD_O,
  output logic [19:0] VEC_ADDR_O,
  input wire logic [7:0] VEC_DATA_I,
  output logic PC_LOAD_O,
  output logic [19:0] PC_ENTRY_O,
  // controller status
  output logic [3:0] BANK_SEL_O,
  output logic [3:0] NEST_CNT_O,
  output logic [3:0] ACC_SRC_O,
  output logic MASTER_EN_O
);

  pic_prio_if pif ();

  // state
  pic_pkg::pic_state_t state_reg; // sequence owner
  pic_pkg::pic_state_t state_next; // next sequence owner
  logic [3:0] step_reg; // step inside a sequence
  logic master_int_enable_reg; // master enable flag
  logic [15:0] source_enable_reg; // individual enables, bits 15..4
  logic [15:0] pending_latch_reg; // request latches, bits 15..2
  logic [15:0] pending_latch_next; // next latch value
  logic soft_pend_reg; // soft trap waiting, has no latch
  logic nmi_busy_reg; // pseudo non-maskable in service
  logic master_saved_reg; // master flag when that service began
  logic nonmaskable_return_reg; // current return is the non-maskable kind
  logic recheck_reg; // sample requests once a return ends
  logic [19:0] vec_reg; // vector address of accepted source
  logic [19:0] entry_reg; // entry address gathered from table
  logic [3:0] bank_code_reg; // bank control nibble from table
  logic [3:0] bank_sel_reg; // bank selector
  logic [3:0] nest_reg; // nesting counter
  logic [3:0] acc_src_reg; // last accepted source
  logic [7:0] rdata_reg; // registered read data
  logic busy_reg; // sequence active
  logic push_reg; // push strobe
  logic pop_reg; // pop strobe
  logic [2:0] stk_sel_reg; // stack byte code
  logic vrd_reg; // vector read strobe
  logic [19:0] vaddr_reg; // vector read address
  logic pc_load_reg; // program counter load strobe

  // register decode
  wire wr_en_lo = SFR_WR_I && (SFR_ADDR_I == pic_pkg::ADDR_EN_LO);
  wire wr_en_hi = SFR_WR_I && (SFR_ADDR_I == pic_pkg::ADDR_EN_HI);
  wire wr_pl_lo = SFR_WR_I && (SFR_ADDR_I == pic_pkg::ADDR_PL_LO);
  wire wr_pl_hi = SFR_WR_I && (SFR_ADDR_I == pic_pkg::ADDR_PL_HI);

  // enable word as software sees it, reserved bits read zero
  wire [15:0] enable_word = (source_enable_reg & pic_pkg::SRC_EN_MASK) |
                            {15'h0000, master_int_enable_reg};

  // read mux; unmapped addresses read zero
  wire [7:0] rdata_next =
    (SFR_ADDR_I == pic_pkg::ADDR_EN_LO) ? enable_word[7:0] :
    (SFR_ADDR_I == pic_pkg::ADDR_EN_HI) ? enable_word[15:8] :
    (SFR_ADDR_I == pic_pkg::ADDR_PL_LO) ? pending_latch_reg[7:0] :
    (SFR_ADDR_I == pic_pkg::ADDR_PL_HI) ? pending_latch_reg[15:8] :
    8'h00;

  // a zero written to a latch bit clears it, a one leaves it
  wire [15:0] sw_clr = {wr_pl_hi ? ~SFR_WDATA_I : 8'h00,
                        wr_pl_lo ? ~SFR_WDATA_I : 8'h00};

  // soft trap counts only outside non-maskable service
  wire soft_req = soft_pend_reg | (SOFT_TRAP_I & ~nmi_busy_reg);

  // nothing is acceptable while a pseudo non-maskable runs
  assign pif.elig[0] = 1'b0;
  assign pif.elig[pic_pkg::SRC_SOFT] = soft_req & ~nmi_busy_reg;
  assign pif.elig[pic_pkg::SRC_WDOG] =
    pending_latch_reg[pic_pkg::SRC_WDOG] & ~nmi_busy_reg;
  assign pif.elig[pic_pkg::SRC_EXT0] = pending_latch_reg[pic_pkg::SRC_EXT0] &
    master_int_enable_reg & EXT0_PIN_EN_I & ~nmi_busy_reg;

  // maskable sources: latch and enable at the same bit
  genvar g;
  generate
    for (g = pic_pkg::FIRST_MASKABLE; g < 16; g++) begin : g_mask
      assign pif.elig[g] = pending_latch_reg[g] & source_enable_reg[g] &
                           master_int_enable_reg & ~nmi_busy_reg;
    end
  endgenerate

  pic_prio_enc u_enc (
    .pif(pif)
  );

  // acceptance: idle, final cycle of an instruction or end of return
  wire go = (state_reg == pic_pkg::PIC_IDLE) &&
            (INSTR_LAST_I || recheck_reg) && pif.hit;
  wire go_nmi = go && (pif.idx <= pic_pkg::SRC_WDOG);
  wire ret_go = (state_reg == pic_pkg::PIC_IDLE) && !go &&
                (MASK_RET_I || NMASK_RET_I);
  wire ret_end = (state_reg == pic_pkg::PIC_RET) && (step_reg == pic_pkg::POP_LAST);
  wire acc_end = (state_reg == pic_pkg::PIC_ACC) && (step_reg == pic_pkg::ACC_LAST);

  // latch of the accepted source clears, request on same cycle wins
  wire [15:0] acc_clr = go ? (16'h0001 << pif.idx) : 16'h0000;

  // vector: reset vector minus four per priority level
  wire [19:0] vec_sel = pic_pkg::VEC_RESET -
                        (20'(pif.idx) << pic_pkg::VEC_SHIFT);

  // latch update per bit; requests set, accept or store clears, external zero also clears while its pin is off
  generate
    for (g = 0; g < 16; g++) begin : g_latch
      if (g == pic_pkg::SRC_EXT0) begin : g_ext0
        // held clear while the pin function is off
        assign pending_latch_next[g] = EXT0_PIN_EN_I &
          ((pending_latch_reg[g] & ~sw_clr[g] & ~acc_clr[g]) | IRQ_I[g]);
      end else begin : g_plain
        assign pending_latch_next[g] = pic_pkg::LATCH_MASK[g] &
          ((pending_latch_reg[g] & ~sw_clr[g] & ~acc_clr[g]) | IRQ_I[g]);
      end
    end
  endgenerate

  // next state of the sequencer
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      pic_pkg::PIC_IDLE: begin
        if (go) begin
          state_next = pic_pkg::PIC_ACC;
        end else if (ret_go) begin
          state_next = pic_pkg::PIC_RET;
        end
      end
      pic_pkg::PIC_ACC: begin
        if (acc_end) begin
          state_next = pic_pkg::PIC_IDLE;
        end
      end
      pic_pkg::PIC_RET: begin
        if (ret_end) begin
          state_next = pic_pkg::PIC_IDLE;
        end
      end
      default: begin
        state_next = pic_pkg::PIC_IDLE; // recover from illegal code
      end
    endcase
  end

  // sequencer and step counter
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      state_reg <= pic_pkg::PIC_IDLE;
      step_reg <= 4'h0;
    end else begin
      state_reg <= state_next;
      step_reg <= (state_next == state_reg) ? step_reg + 4'h1 : 4'h0;
    end
  end

  // request latches and soft trap flag
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      pending_latch_reg <= pic_pkg::LATCH_RESET;
      soft_pend_reg <= 1'b0;
    end else begin
      pending_latch_reg <= pending_latch_next;
      soft_pend_reg <= soft_req & ~(go && pif.idx == pic_pkg::SRC_SOFT);
    end
  end

  // individual enables: plain byte writes; cpu does bit ops by rmw
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      source_enable_reg <= pic_pkg::ENABLE_RESET;
    end else begin
      if (wr_en_lo) begin
        source_enable_reg[7:0] <= SFR_WDATA_I & pic_pkg::SRC_EN_MASK[7:0];
      end
      if (wr_en_hi) begin
        source_enable_reg[15:8] <= SFR_WDATA_I & pic_pkg::SRC_EN_MASK[15:8];
      end
    end
  end

  // master enable: accept clears, returns restore, stores write
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      master_int_enable_reg <= 1'b0;
    end else if (go) begin
      master_int_enable_reg <= 1'b0;
    end else if (ret_end) begin
      // maskable return always sets; non-maskable only if set before
      master_int_enable_reg <= nonmaskable_return_reg ? master_saved_reg : 1'b1;
    end else if (wr_en_lo) begin
      master_int_enable_reg <= SFR_WDATA_I[pic_pkg::MASTER_BIT];
    end
  end

  // non-maskable bookkeeping
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      nmi_busy_reg <= 1'b0;
      master_saved_reg <= 1'b0;
      nonmaskable_return_reg <= 1'b0;
    end else begin
      if (go_nmi) begin
        nmi_busy_reg <= 1'b1;
        master_saved_reg <= master_int_enable_reg;
      end else if (ret_end && nonmaskable_return_reg) begin
        nmi_busy_reg <= 1'b0;
      end
      if (ret_go) begin
        nonmaskable_return_reg <= NMASK_RET_I;
      end
    end
  end

  // nesting counter, bank selector, recheck after return
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      nest_reg <= 4'h0;
      bank_sel_reg <= 4'h0;
      recheck_reg <= 1'b0;
      acc_src_reg <= 4'h0;
    end else begin
      recheck_reg <= ret_end;
      if (go) begin
        nest_reg <= nest_reg + 4'h1;
        acc_src_reg <= pif.idx;
      end else if (ret_end && nest_reg != 4'h0) begin
        nest_reg <= nest_reg - 4'h1;
      end
      if (acc_end) begin
        bank_sel_reg <= bank_sel_reg + bank_code_reg;
      end else if (ret_end) begin
        bank_sel_reg <= RET_BANK_I; // bank comes back with the status word
      end
    end
  end

  // vector table capture; entry bytes low first, then bank code
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      vec_reg <= pic_pkg::VEC_RESET;
      entry_reg <= 20'h00000;
      bank_code_reg <= 4'h0;
    end else begin
      if (go) begin
        vec_reg <= vec_sel;
      end
      if (state_reg == pic_pkg::PIC_ACC) begin
        if (step_reg == pic_pkg::CAP_FIRST) begin
          entry_reg[7:0] <= VEC_DATA_I;
        end
        if (step_reg == pic_pkg::CAP_MID) begin
          entry_reg[15:8] <= VEC_DATA_I;
        end
        if (step_reg == pic_pkg::CAP_TOP) begin
          entry_reg[19:16] <= VEC_DATA_I[3:0];
        end
        if (step_reg == pic_pkg::CAP_BANK) begin
          bank_code_reg <= VEC_DATA_I[3:0]; // only low nibble used
        end
      end
    end
  end

  // strobes to the core; only status and pc go on the stack
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      busy_reg <= 1'b0;
      push_reg <= 1'b0;
      pop_reg <= 1'b0;
      stk_sel_reg <= pic_pkg::STK_PSWH;
      vrd_reg <= 1'b0;
      vaddr_reg <= pic_pkg::VEC_RESET;
      pc_load_reg <= 1'b0;
      rdata_reg <= 8'h00;
    end else begin
      busy_reg <= (state_next != pic_pkg::PIC_IDLE);
      push_reg <= (state_reg == pic_pkg::PIC_ACC) &&
                  (step_reg <= pic_pkg::PUSH_LAST);
      pop_reg <= (state_reg == pic_pkg::PIC_RET);
      // pushes walk status high to pc low; pops walk back
      stk_sel_reg <= (state_reg == pic_pkg::PIC_RET) ?
                     pic_pkg::STK_PCL - step_reg[2:0] : step_reg[2:0];
      vrd_reg <= (state_reg == pic_pkg::PIC_ACC) &&
                 (step_reg >= pic_pkg::VRD_FIRST) && (step_reg <= pic_pkg::VRD_LAST);
      vaddr_reg <= vec_reg + 20'(step_reg - pic_pkg::VRD_FIRST);
      pc_load_reg <= acc_end;
      rdata_reg <= rdata_next;
    end
  end

  // outputs straight from flip-flops
  assign SFR_RDATA_O = rdata_reg;
  assign BUSY_O = busy_reg;
  assign STACK_PUSH_O = push_reg;
  assign STACK_POP_O = pop_reg;
  assign STACK_SEL_O = stk_sel_reg;
  assign VEC_RD_O = vrd_reg;
  assign VEC_ADDR_O = vaddr_reg;
  assign PC_LOAD_O = pc_load_reg;
  assign PC_ENTRY_O = entry_reg;
  assign BANK_SEL_O = bank_sel_reg;
  assign NEST_CNT_O = nest_reg;
  assign ACC_SRC_O = acc_src_reg;
  assign MASTER_EN_O = master_int_enable_reg;

endmodule : pic_ctrl
`default_nettype wire

// >>> pic_ctrl_props.sv
// assertion checker bound to the interrupt controller top
`timescale 1ns/1ps
`default_nettype none
module pic_ctrl_props (
  // clock and reset
  input wire logic CLK_I,
  input wire logic SYS_RST_I,
  // register writes and cpu events
  input wire logic [19:0] SFR_ADDR_I,
  input wire logic SFR_WR_I,
  input wire logic [7:0] SFR_WDATA_I,
  input wire logic INSTR_LAST_I,
  input wire logic SOFT_TRAP_I,
  input wire logic MASK_RET_I,
  // controller answers
  input wire logic BUSY_O,
  input wire logic STACK_PUSH_O,
  input wire logic STACK_POP_O,
  input wire logic [2:0] STACK_SEL_O,
  input wire logic VEC_RD_O,
  input wire logic [19:0] VEC_ADDR_O,
  input wire logic PC_LOAD_O,
  input wire logic [3:0] NEST_CNT_O,
  input wire logic [3:0] ACC_SRC_O,
  input wire logic MASTER_EN_O
);
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (SYS_RST_I);
  // one stack byte moved with a given code
  sequence s_push(logic [2:0] k);
    STACK_PUSH_O && STACK_SEL_O == k;
  endsequence
  sequence s_pop(logic [2:0] k);
    STACK_POP_O && STACK_SEL_O == k;
  endsequence
  // acceptance start: busy rises, pushing follows
  sequence s_acc;
    $rose(BUSY_O) ##1 STACK_PUSH_O;
  endsequence
  property p_push_order;
    s_push(3'h0) |=> s_push(3'h1) ##1 s_push(3'h2) ##1 s_push(3'h3) ##1 s_push(3'h4);
  endproperty
  a_push_order: assert property (p_push_order) else $error("push order wrong");
  property p_acc_len;
    s_push(3'h0) |-> BUSY_O [*8] ##1 BUSY_O [*3] ##1 (!BUSY_O && PC_LOAD_O);
  endproperty
  a_acc_len: assert property (p_acc_len) else $error("acceptance length wrong");
  // four table reads from the source's own vector upward
  property p_vec_seq;
    s_push(3'h4) |=> VEC_RD_O && VEC_ADDR_O == pic_pkg::VEC_RESET - {14'h0, ACC_SRC_O, 2'h0}
      ##1 (VEC_RD_O && VEC_ADDR_O == $past(VEC_ADDR_O) + 20'h1) [*3];
  endproperty
  a_vec_seq: assert property (p_vec_seq) else $error("vector fetch wrong");
  property p_master_clr;
    s_acc |-> !MASTER_EN_O;
  endproperty
  a_master_clr: assert property (p_master_clr) else $error("master kept on accept");
  // a maskable winner needs the master flag as it stood when taken
  property p_gate;
    s_acc |-> $past(MASTER_EN_O, 2) || ACC_SRC_O < 4'h3;
  endproperty
  a_gate: assert property (p_gate) else $error("accepted while masked");
  property p_pop_order;
    s_pop(3'h4) |=> s_pop(3'h3) ##1 s_pop(3'h2) ##1 s_pop(3'h1) ##1 s_pop(3'h0);
  endproperty
  a_pop_order: assert property (p_pop_order) else $error("pop order wrong");
  property p_nest_dec;
    s_pop(3'h0) |-> NEST_CNT_O == ($past(NEST_CNT_O, 5) == 4'h0 ? 4'h0 : $past(NEST_CNT_O, 5) - 4'h1);
  endproperty
  a_nest_dec: assert property (p_nest_dec) else $error("nesting count wrong");
  property p_master_ret;
    MASK_RET_I && !BUSY_O && !INSTR_LAST_I && !SOFT_TRAP_I |-> ##6 MASTER_EN_O;
  endproperty
  a_master_ret: assert property (p_master_ret) else $error("return left master off");
  // a low enable byte write lands in the master flag next cycle
  property p_en_wr;
    SFR_WR_I && SFR_ADDR_I == pic_pkg::ADDR_EN_LO && !BUSY_O && !INSTR_LAST_I && !SOFT_TRAP_I
      |=> MASTER_EN_O == $past(SFR_WDATA_I[0]);
  endproperty
  a_en_wr: assert property (p_en_wr) else $error("master write lost");
endmodule : pic_ctrl_props
bind pic_ctrl pic_ctrl_props u_props (.CLK_I(CLK_I), .SYS_RST_I(SYS_RST_I),
  .SFR_ADDR_I(SFR_ADDR_I), .SFR_WR_I(SFR_WR_I), .SFR_WDATA_I(SFR_WDATA_I),
  .INSTR_LAST_I(INSTR_LAST_I), .SOFT_TRAP_I(SOFT_TRAP_I), .MASK_RET_I(MASK_RET_I),
  .BUSY_O(BUSY_O), .STACK_PUSH_O(STACK_PUSH_O), .STACK_POP_O(STACK_POP_O),
  .STACK_SEL_O(STACK_SEL_O), .VEC_RD_O(VEC_RD_O), .VEC_ADDR_O(VEC_ADDR_O),
  .PC_LOAD_O(PC_LOAD_O), .NEST_CNT_O(NEST_CNT_O), .ACC_SRC_O(ACC_SRC_O),
  .MASTER_EN_O(MASTER_EN_O));
`default_nettype wire

// >>> pic_cpu_model.sv
// cpu core stand-in: vector table, stack pointer, saved bank
`timescale 1ns/1ps
`default_nettype none
module pic_cpu_model (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // requests from the controller
  input wire logic push_i,
  input wire logic pop_i,
  input wire logic [2:0] sel_i,
  input wire logic vec_rd_i,
  input wire logic [19:0] vec_addr_i,
  input wire logic [3:0] bank_i,
  // answers to the controller
  output logic [7:0] vec_data_o,
  output logic [3:0] ret_bank_o,
  output logic [7:0] sp_o
);
  // table byte is a scramble of its address; idle bus toggles
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      vec_data_o <= 8'h00;
    end else if (vec_rd_i) begin
      vec_data_o <= vec_addr_i[7:0] ^ 8'h5A;
    end else begin
      vec_data_o <= ~vec_data_o;
    end
  end
  // stack pointer moves once per byte; bank rides with status
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sp_o <= 8'h00;
      ret_bank_o <= 4'h0;
    end else if (push_i) begin
      sp_o <= sp_o - 8'h01;
      if (sel_i == pic_pkg::STK_PSWH) ret_bank_o <= bank_i;
    end else if (pop_i) begin
      sp_o <= sp_o + 8'h01;
    end
  end
endmodule : pic_cpu_model
`default_nettype wire

// >>> prioritized_interrupt_controller_test.sv
// self-checking bench for the prioritized interrupt controller
`timescale 1ns/1ps
`default_nettype none
module prioritized_interrupt_controller_test;
  logic clk = 1'b0, rst = 1'b1, wr = 1'b0, pin_en = 1'b1; // driven inputs
  logic last = 1'b0, strap = 1'b0, mret = 1'b0, nret = 1'b0; // cpu events
  logic [19:0] addr = 20'h00000; // register address
  logic [7:0] wdata = 8'h00;
  logic [15:0] irq = 16'h0000; // request lines
  logic [7:0] rdata, vdata, sp, rv; // read data, table data, stack pointer
  logic [3:0] rbank, bank, nest, src;
  logic busy, push, pop, vrd, pcl, master;
  logic [2:0] sel;
  logic [19:0] vaddr, entry;
  int failures = 0, check_count = 0;
  // rows: source number is the index, its vector beside it
  logic [19:0] vec_tab [1:15] = '{20'hFFFF8, 20'hFFFF4, 20'hFFFF0, 20'hFFFEC, 20'hFFFE8,
    20'hFFFE4, 20'hFFFE0, 20'hFFFDC, 20'hFFFD8, 20'hFFFD4, 20'hFFFD0, 20'hFFFCC,
    20'hFFFC8, 20'hFFFC4, 20'hFFFC0};
  always #50 clk = ~clk;
  pic_ctrl u_dut (.CLK_I(clk), .SYS_RST_I(rst), .SFR_ADDR_I(addr), .SFR_WR_I(wr),
    .SFR_WDATA_I(wdata), .SFR_RDATA_O(rdata), .IRQ_I(irq), .EXT0_PIN_EN_I(pin_en),
    .INSTR_LAST_I(last), .SOFT_TRAP_I(strap), .MASK_RET_I(mret), .NMASK_RET_I(nret),
    .RET_BANK_I(rbank), .BUSY_O(busy), .STACK_PUSH_O(push), .STACK_POP_O(pop),
    .STACK_SEL_O(sel), .VEC_RD_O(vrd), .VEC_ADDR_O(vaddr), .VEC_DATA_I(vdata),
    .PC_LOAD_O(pcl), .PC_ENTRY_O(entry), .BANK_SEL_O(bank), .NEST_CNT_O(nest),
    .ACC_SRC_O(src), .MASTER_EN_O(master));
  pic_cpu_model u_cpu (.clk_i(clk), .rst_i(rst), .push_i(push), .pop_i(pop), .sel_i(sel),
    .vec_rd_i(vrd), .vec_addr_i(vaddr), .bank_i(bank), .vec_data_o(vdata),
    .ret_bank_o(rbank), .sp_o(sp));
  // expected table byte, same scramble as the core stand-in
  function automatic logic [7:0] tbl(input logic [19:0] a);
    return a[7:0] ^ 8'h5A;
  endfunction : tbl
  task automatic chk(input logic [19:0] got, input logic [19:0] exp);
    check_count++;
    if (got !== exp) begin
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      failures++;
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask : tick
  task automatic wreg(input logic [19:0] a, input logic [7:0] d);
    @(negedge clk);
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(negedge clk);
    wr = 1'b0;
  endtask : wreg
  // read data comes one cycle after the address
  task automatic rreg(input logic [19:0] a, output logic [7:0] d);
    @(negedge clk);
    addr = a;
    @(negedge clk);
    d = rdata;
  endtask : rreg
  // final cycle of an instruction, optionally the soft trap
  task automatic step(input logic s);
    @(negedge clk);
    last = 1'b1;
    strap = s;
    @(negedge clk);
    last = 1'b0;
    strap = 1'b0;
  endtask : step
  task automatic pulse(input logic [15:0] m);
    @(negedge clk);
    irq = m;
    @(negedge clk);
    irq = 16'h0000;
  endtask : pulse
  // bounded wait for the entry load at the end of acceptance
  task automatic wait_pc;
    int k;
    for (k = 0; k < 60; k++) begin
      @(negedge clk);
      if (pcl === 1'b1) break;
    end
    chk(pcl, 20'h1);
  endtask : wait_pc
  task automatic ret(input logic m);
    @(negedge clk);
    mret = m;
    nret = !m;
    @(negedge clk);
    mret = 1'b0;
    nret = 1'b0;
    tick(8);
  endtask : ret
  task automatic complete_run;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : complete_run
  // hang guard at 20000 cycles, far beyond the several hundred cycles needed
  initial begin
    #(20000 * 100);
    failures++;
    complete_run();
  end
  initial begin
    logic [19:0] v;
    logic [7:0] t;
    tick(12);
    rst = 1'b0;
    chk(vaddr, pic_pkg::VEC_RESET);
    chk(master, 20'h0);
    rreg(pic_pkg::ADDR_EN_LO, rv);
    chk(rv, 20'h0);
    rreg(pic_pkg::ADDR_PL_LO, rv);
    chk(rv, 20'h0);
    rreg(20'h00040, rv);
    chk(rv, 20'h0);
    // every source once: accept, check entry and bank, return
    for (logic [4:0] i = 5'h1; i < 5'h10; i++) begin
      wreg(pic_pkg::ADDR_EN_LO, 8'hF0);
      wreg(pic_pkg::ADDR_EN_HI, 8'hFF);
      wreg(pic_pkg::ADDR_EN_LO, 8'hF1);
      rreg(pic_pkg::ADDR_EN_LO, rv);
      chk(rv, 20'hF1);
      if (i == 5'h1) step(1'b1);
      else begin
        pulse(16'h0001 << i);
        step(1'b0);
      end
      wait_pc();
      v = vec_tab[i];
      t = tbl(v + 20'h2);
      chk(src, i);
      chk(entry, {t[3:0], tbl(v + 20'h1), tbl(v)});
      t = tbl(v + 20'h3);
      chk(bank, t[3:0]);
      chk(master, 20'h0);
      chk(sp, 20'hFB);
      rreg(pic_pkg::ADDR_PL_HI, rv);
      chk(rv, 20'h0);
      ret(i > 5'h2);
      chk(master, 20'h1);
      chk({nest, bank, sp}, 20'h0);
    end
    // three at once: lowest number first, the rest chained after returns
    wreg(pic_pkg::ADDR_EN_LO, 8'hF0);
    pulse(16'h8210);
    wreg(pic_pkg::ADDR_EN_LO, 8'hF1);
    step(1'b0);
    wait_pc();
    chk(src, 20'h4);
    ret(1'b1);
    wait_pc();
    chk(src, 20'h9);
    ret(1'b1);
    wait_pc();
    chk(src, 20'hF);
    ret(1'b1);
    // latch reads, clear-only writes, pin-disabled external zero
    wreg(pic_pkg::ADDR_EN_LO, 8'hF0);
    pin_en = 1'b0;
    pulse(16'h0868);
    rreg(pic_pkg::ADDR_PL_LO, rv);
    chk(rv, 20'h60);
    rreg(pic_pkg::ADDR_PL_HI, rv);
    chk(rv, 20'h08);
    wreg(pic_pkg::ADDR_PL_LO, 8'hDF);
    rreg(pic_pkg::ADDR_PL_LO, rv);
    chk(rv, 20'h40);
    wreg(pic_pkg::ADDR_PL_LO, 8'hFF);
    rreg(pic_pkg::ADDR_PL_LO, rv);
    chk(rv, 20'h40);
    wreg(pic_pkg::ADDR_PL_LO, 8'h00);
    wreg(pic_pkg::ADDR_PL_HI, 8'h00);
    // pending source held off by master, then by its own flag
    pulse(16'h0010);
    step(1'b0);
    tick(2);
    chk(busy, 20'h0);
    wreg(pic_pkg::ADDR_EN_LO, 8'hE1);
    step(1'b0);
    tick(2);
    chk(busy, 20'h0);
    // master off first, enables left as they are
    wreg(pic_pkg::ADDR_EN_LO, 8'hE0);
    wreg(pic_pkg::ADDR_PL_LO, 8'h00);
    // soft trap with master off blocks watchdog and a second trap
    step(1'b1);
    wait_pc();
    chk(src, 20'h1);
    pulse(16'h0004);
    step(1'b0);
    tick(3);
    chk(busy, 20'h0);
    step(1'b1);
    tick(3);
    chk(busy, 20'h0);
    ret(1'b0);
    chk(master, 20'h0);
    wait_pc();
    chk(src, 20'h2);
    ret(1'b0);
    chk(master, 20'h0);
    step(1'b0);
    tick(2);
    chk(busy, 20'h0);
    // mid-run reset wipes a set latch and the master flag
    wreg(pic_pkg::ADDR_EN_LO, 8'h01);
    pulse(16'h0040);
    rst = 1'b1;
    tick(2);
    rst = 1'b0;
    rreg(pic_pkg::ADDR_PL_LO, rv);
    chk(rv, 20'h0);
    rreg(pic_pkg::ADDR_EN_LO, rv);
    chk(rv, 20'h0);
    complete_run();
  end
endmodule : prioritized_interrupt_controller_test
`default_nettype wire
